/* File: verilog/lsd_pkg.sv */
// Constants and carrier types for the link status and diagnostic registers.
package lsd_pkg;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    // Register indices; the byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_BACKLINK_CTRL = 10'h049;
    localparam logic [IDX_W-1:0] IDX_LINK_GENERAL_FLAGS = 10'h052;
    localparam logic [IDX_W-1:0] IDX_INPUT_PIN_LEVELS = 10'h053;
    localparam logic [IDX_W-1:0] IDX_SELFTEST_FAIL_COUNT = 10'h054;
    localparam logic [IDX_W-1:0] IDX_CHECK_COUNT_LOW = 10'h055;
    localparam logic [IDX_W-1:0] IDX_CHECK_COUNT_HIGH = 10'h056;
    localparam logic [IDX_W-1:0] IDX_MONITOR_ALARM_FLAGS = 10'h057;
    localparam logic [IDX_W-1:0] IDX_PIN0_VOLTAGE_EXTREMES = 10'h058;
    localparam logic [IDX_W-1:0] IDX_PIN1_VOLTAGE_EXTREMES = 10'h059;
    localparam logic [IDX_W-1:0] IDX_PIN_DIRECTION = 10'h070;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // General flags field positions.
    localparam int GEN_REMOTE_LOCK = 6;
    localparam int GEN_LINK_LOST = 4;
    localparam int GEN_SELFTEST_FAIL = 3;
    localparam int GEN_PLL_LOCKED = 2;
    localparam int GEN_CHECK_ERR = 1;
    localparam int GEN_BACKLINK_VALID = 0;
    // Back-link control fields.
    localparam int CTRL_CHECK_CLEAR = 3;
    localparam int CTRL_SELFTEST_CLEAR = 5;
    localparam logic [7:0] CTRL_KEEP_MASK = 8'h17;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Alarm flag positions.
    localparam int ALM_TEMP_OVER = 5;
    localparam int ALM_TEMP_UNDER = 4;
    localparam int ALM_PIN1_OVER = 3;
    localparam int ALM_PIN1_UNDER = 2;
    localparam int ALM_PIN0_OVER = 1;
    localparam int ALM_PIN0_UNDER = 0;
    // Voltage extremes fields.
    localparam int PEAK_LSB = 4;
    localparam int TROUGH_LSB = 0;
    localparam logic [2:0] PEAK_RESET = 3'h0;
    localparam logic [2:0] TROUGH_RESET = 3'h7;
    localparam logic [3:0] PIN_DIR_RESET = 4'hf;
    localparam logic [7:0] COUNT8_MAX = 8'hff;
    localparam logic [15:0] COUNT16_MAX = 16'hffff;

    typedef struct packed {
        logic remote_lock;
        logic backlink_valid;
        logic backlink_err;
        logic selftest_mode;
        logic fwd_highspeed_pll_locked;
    } lsd_link_s;

    typedef struct packed {
        logic sample_valid;
        logic [7:0] temp_reading;
        logic [7:0] temp_upper_limit;
        logic [7:0] temp_lower_limit;
        logic [2:0] pin0_reading;
        logic [2:0] pin0_upper_limit;
        logic [2:0] pin0_lower_limit;
        logic [2:0] pin1_reading;
        logic [2:0] pin1_upper_limit;
        logic [2:0] pin1_lower_limit;
    } lsd_sense_s;

    typedef struct packed {
        logic [3:0] pin_meta;
        logic [3:0] pin_sync;
        logic [3:0] input_pin_levels;
        logic [3:0] pin_dir;
        logic remote_lock;
        logic backlink_valid;
        logic pll_locked;
        logic link_lost;
        logic check_flag;
        logic selftest_fail_flag;
        logic [7:0] selftest_fail_count;
        logic [15:0] check_count;
        logic [5:0] alarms;
        logic [2:0] pin0_peak_reading;
        logic [2:0] pin0_trough_reading;
        logic [2:0] pin1_peak_reading;
        logic [2:0] pin1_trough_reading;
        logic [7:0] ctrl;
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] aw_addr;
        logic [7:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } lsd_state_s;
endpackage : lsd_pkg

/* File: verilog/lsd_regs.sv */
// Link status and diagnostic register bank behind an AXI4-Lite slave.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

module lsd_regs
    import lsd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [3:0] gpio_pin,
    input wire lsd_link_s link_i,
    input wire lsd_sense_s sense_i
);

    lsd_state_s state_q;
    lsd_state_s state_d;

    // An index is mapped only when it matches one of the ten register indices.
    function automatic logic lsd_mapped(input logic [IDX_W-1:0] idx);
        unique case (idx)
            IDX_BACKLINK_CTRL, IDX_LINK_GENERAL_FLAGS, IDX_INPUT_PIN_LEVELS,
            IDX_SELFTEST_FAIL_COUNT, IDX_CHECK_COUNT_LOW,
            IDX_CHECK_COUNT_HIGH, IDX_MONITOR_ALARM_FLAGS,
            IDX_PIN0_VOLTAGE_EXTREMES, IDX_PIN1_VOLTAGE_EXTREMES,
            IDX_PIN_DIRECTION: lsd_mapped = 1'b1;
            default: lsd_mapped = 1'b0;
        endcase
    endfunction : lsd_mapped

    logic rd_fire;
    logic wr_fire;
    logic [IDX_W-1:0] rd_idx;
    logic [IDX_W-1:0] wr_idx;
    logic check_event;
    logic selftest_event;
    logic check_clear;
    logic selftest_clear;
    logic pll_loss;

    assign rd_fire = arvalid && state_q.arready;
    assign rd_idx = araddr[ADDR_W-1:2];
    assign wr_fire = state_q.aw_held && state_q.w_held && !state_q.bvalid;
    assign wr_idx = state_q.aw_addr[ADDR_W-1:2];
    // Errors during self-test go to the self-test counter only.
    assign check_event = link_i.backlink_err && link_i.backlink_valid
        && !link_i.selftest_mode;
    assign selftest_event = link_i.backlink_err && link_i.selftest_mode;
    assign pll_loss = state_q.pll_locked && !link_i.fwd_highspeed_pll_locked;
    assign check_clear = wr_fire && wr_idx == IDX_BACKLINK_CTRL
        && state_q.w_lane0 && state_q.w_data[CTRL_CHECK_CLEAR];
    assign selftest_clear = wr_fire && wr_idx == IDX_BACKLINK_CTRL
        && state_q.w_lane0 && state_q.w_data[CTRL_SELFTEST_CLEAR];

    always_comb begin
        logic [7:0] rv;
        logic rd_clear_ctrl;
        rv = 8'h00;
        rd_clear_ctrl = rd_fire && rd_idx == IDX_BACKLINK_CTRL;
        state_d = state_q;

        // Pins are asynchronous, so two flops precede any use.
        state_d.pin_meta = gpio_pin;
        state_d.pin_sync = state_q.pin_meta;
        for (int i = 0; i < 4; i++) begin
            if (state_q.pin_dir[i]) begin
                state_d.input_pin_levels[i] = state_q.pin_sync[i];
            end
        end
        state_d.remote_lock = link_i.remote_lock;
        state_d.backlink_valid = link_i.backlink_valid;
        state_d.pll_locked = link_i.fwd_highspeed_pll_locked;

        // Clears come first so that a same-cycle event still sets.
        if (rd_clear_ctrl || pll_loss) begin
            state_d.link_lost = 1'b0;
        end
        if (rd_clear_ctrl || check_clear) begin
            state_d.check_flag = 1'b0;
        end
        if (check_clear) begin
            state_d.check_count = 16'h0000;
        end
        if (selftest_clear) begin
            state_d.selftest_fail_count = 8'h00;
            state_d.selftest_fail_flag = 1'b0;
        end
        if (link_i.backlink_valid != state_q.backlink_valid) begin
            state_d.link_lost = 1'b1;
        end
        if (check_event) begin
            state_d.check_flag = 1'b1;
            if (state_d.check_count != COUNT16_MAX) begin
                state_d.check_count = state_d.check_count + 16'h0001;
            end
        end
        if (selftest_event) begin
            state_d.selftest_fail_flag = 1'b1;
            if (state_d.selftest_fail_count != COUNT8_MAX) begin
                state_d.selftest_fail_count =
                    state_d.selftest_fail_count + 8'h01;
            end
        end

        // Clear-on-read of alarms and extremes, then new samples on top.
        if (rd_fire && rd_idx == IDX_MONITOR_ALARM_FLAGS) begin
            state_d.alarms = 6'h00;
        end
        if (rd_fire && rd_idx == IDX_PIN0_VOLTAGE_EXTREMES) begin
            state_d.pin0_peak_reading = PEAK_RESET;
            state_d.pin0_trough_reading = TROUGH_RESET;
        end
        if (rd_fire && rd_idx == IDX_PIN1_VOLTAGE_EXTREMES) begin
            state_d.pin1_peak_reading = PEAK_RESET;
            state_d.pin1_trough_reading = TROUGH_RESET;
        end
        if (sense_i.sample_valid) begin
            if (sense_i.temp_reading > sense_i.temp_upper_limit) begin
                state_d.alarms[ALM_TEMP_OVER] = 1'b1;
            end
            if (sense_i.temp_reading < sense_i.temp_lower_limit) begin
                state_d.alarms[ALM_TEMP_UNDER] = 1'b1;
            end
            if (sense_i.pin1_reading > sense_i.pin1_upper_limit) begin
                state_d.alarms[ALM_PIN1_OVER] = 1'b1;
                if (sense_i.pin1_reading > state_d.pin1_peak_reading) begin
                    state_d.pin1_peak_reading = sense_i.pin1_reading;
                end
            end
            if (sense_i.pin1_reading < sense_i.pin1_lower_limit) begin
                state_d.alarms[ALM_PIN1_UNDER] = 1'b1;
                if (sense_i.pin1_reading < state_d.pin1_trough_reading) begin
                    state_d.pin1_trough_reading = sense_i.pin1_reading;
                end
            end
            if (sense_i.pin0_reading > sense_i.pin0_upper_limit) begin
                state_d.alarms[ALM_PIN0_OVER] = 1'b1;
                if (sense_i.pin0_reading > state_d.pin0_peak_reading) begin
                    state_d.pin0_peak_reading = sense_i.pin0_reading;
                end
            end
            if (sense_i.pin0_reading < sense_i.pin0_lower_limit) begin
                state_d.alarms[ALM_PIN0_UNDER] = 1'b1;
                if (sense_i.pin0_reading < state_d.pin0_trough_reading) begin
                    state_d.pin0_trough_reading = sense_i.pin0_reading;
                end
            end
        end

        // Write channel: address and data may arrive in either order.
        if (awvalid && state_q.awready) begin
            state_d.aw_held = 1'b1;
            state_d.aw_addr = awaddr;
        end
        if (wvalid && state_q.wready) begin
            state_d.w_held = 1'b1;
            state_d.w_data = wdata[7:0];
            state_d.w_lane0 = wstrb[0];
        end
        if (wr_fire) begin
            state_d.aw_held = 1'b0;
            state_d.w_held = 1'b0;
            state_d.bvalid = 1'b1;
            state_d.bresp = lsd_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
            // Only the two control words hold writable bits.
            if (state_q.w_lane0 && wr_idx == IDX_BACKLINK_CTRL) begin
                state_d.ctrl = state_q.w_data & CTRL_KEEP_MASK;
            end
            if (state_q.w_lane0 && wr_idx == IDX_PIN_DIRECTION) begin
                state_d.pin_dir = state_q.w_data[3:0];
            end
        end else if (state_q.bvalid && bready) begin
            state_d.bvalid = 1'b0;
        end
        state_d.awready = !state_d.aw_held;
        state_d.wready = !state_d.w_held;

        // Read channel: the answer is captured at the taking edge.
        unique case (rd_idx)
            IDX_BACKLINK_CTRL: rv = state_q.ctrl;
            IDX_LINK_GENERAL_FLAGS: begin
                rv[GEN_REMOTE_LOCK] = state_q.remote_lock;
                rv[GEN_LINK_LOST] = state_q.link_lost;
                rv[GEN_SELFTEST_FAIL] = state_q.selftest_fail_flag;
                rv[GEN_PLL_LOCKED] = state_q.pll_locked;
                rv[GEN_CHECK_ERR] = state_q.check_flag;
                rv[GEN_BACKLINK_VALID] = state_q.backlink_valid;
            end
            IDX_INPUT_PIN_LEVELS: rv = {4'h0, state_q.input_pin_levels};
            IDX_SELFTEST_FAIL_COUNT: rv = state_q.selftest_fail_count;
            IDX_CHECK_COUNT_LOW: rv = state_q.check_count[7:0];
            IDX_CHECK_COUNT_HIGH: rv = state_q.check_count[15:8];
            IDX_MONITOR_ALARM_FLAGS: rv = {2'h0, state_q.alarms};
            IDX_PIN0_VOLTAGE_EXTREMES: begin
                rv[PEAK_LSB +: 3] = state_q.pin0_peak_reading;
                rv[TROUGH_LSB +: 3] = state_q.pin0_trough_reading;
            end
            IDX_PIN1_VOLTAGE_EXTREMES: begin
                rv[PEAK_LSB +: 3] = state_q.pin1_peak_reading;
                rv[TROUGH_LSB +: 3] = state_q.pin1_trough_reading;
            end
            IDX_PIN_DIRECTION: rv = {4'h0, state_q.pin_dir};
            default: rv = 8'h00;
        endcase
        if (rd_fire) begin
            state_d.arready = 1'b0;
            state_d.rvalid = 1'b1;
            state_d.rdata = {24'h000000, rv};
            state_d.rresp = lsd_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (state_q.rvalid && rready) begin
            state_d.rvalid = 1'b0;
            state_d.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= '0;
            state_q.pin_dir <= PIN_DIR_RESET;
            state_q.backlink_valid <= 1'b1;
            state_q.pll_locked <= 1'b1;
            state_q.pin0_trough_reading <= TROUGH_RESET;
            state_q.pin1_trough_reading <= TROUGH_RESET;
            state_q.ctrl <= CTRL_RESET;
            state_q.awready <= 1'b1;
            state_q.wready <= 1'b1;
            state_q.arready <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    assign awready = state_q.awready;
    assign wready = state_q.wready;
    assign bvalid = state_q.bvalid;
    assign bresp = state_q.bresp;
    assign arready = state_q.arready;
    assign rvalid = state_q.rvalid;
    assign rdata = state_q.rdata;
    assign rresp = state_q.rresp;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence pins_steady_inputs;
        (&state_q.pin_dir && $stable(gpio_pin))[*4];
    endsequence

    sequence ctrl_read_taken;
        rd_fire && rd_idx == IDX_BACKLINK_CTRL;
    endsequence

    AST_CHECK_SET: assert property (
        check_event |=> state_q.check_flag && state_q.check_count != 16'h0000)
        else $error("checksum event did not set flag and count");

    AST_CHECK_HOLD: assert property (
        state_q.check_flag && !check_clear
        && !(rd_fire && rd_idx == IDX_BACKLINK_CTRL) |=> state_q.check_flag)
        else $error("checksum flag dropped without a clear");

    AST_CTRL_READ_CLEARS: assert property (
        ctrl_read_taken ##0 (!check_event
        && link_i.backlink_valid == state_q.backlink_valid)
        |=> !state_q.link_lost && !state_q.check_flag)
        else $error("control read did not clear link flags");

    AST_LINK_CHANGE: assert property (
        link_i.backlink_valid != state_q.backlink_valid
        |=> state_q.link_lost
        && state_q.backlink_valid == $past(link_i.backlink_valid))
        else $error("link change not flagged");

    AST_SELFTEST_SAT: assert property (
        state_q.selftest_fail_count == COUNT8_MAX && !selftest_clear
        |=> state_q.selftest_fail_count == COUNT8_MAX)
        else $error("self-test counter wrapped");

    AST_SELFTEST_CLEAR: assert property (
        selftest_clear && !selftest_event
        |=> state_q.selftest_fail_count == 8'h00
        && !state_q.selftest_fail_flag)
        else $error("self-test counter not cleared by command");

    AST_PIN_LEVELS: assert property (
        pins_steady_inputs |-> state_q.input_pin_levels == $past(gpio_pin, 3))
        else $error("pin levels do not follow steady input pins");

    AST_ALARM_READ: assert property (
        rd_fire && rd_idx == IDX_MONITOR_ALARM_FLAGS && !sense_i.sample_valid
        |=> state_q.alarms == 6'h00 && rvalid)
        else $error("alarm read did not clear flags");

    AST_TROUGH_READ: assert property (
        rd_fire && rd_idx == IDX_PIN0_VOLTAGE_EXTREMES && !sense_i.sample_valid
        |=> state_q.pin0_trough_reading == TROUGH_RESET
        && state_q.pin0_peak_reading == PEAK_RESET)
        else $error("pin0 extremes not cleared on read");

    AST_READ_ANSWER: assert property (
        rd_fire |=> rvalid && !arready
        && rdata[31:8] == 24'h000000)
        else $error("read answer missing or upper bits set");

    AST_LEVELS_FOLLOW: assert property (
        aresetn |=> state_q.remote_lock == $past(link_i.remote_lock)
        && state_q.pll_locked == $past(link_i.fwd_highspeed_pll_locked)
        && state_q.backlink_valid == $past(link_i.backlink_valid))
        else $error("link levels not mirrored one edge late");

    AST_PLL_LOSS: assert property (
        pll_loss && link_i.backlink_valid == state_q.backlink_valid
        |=> !state_q.link_lost)
        else $error("forward lock loss did not clear link-lost flag");

    AST_SELFTEST_SET: assert property (
        selftest_event |=> state_q.selftest_fail_flag
        && state_q.selftest_fail_count != 8'h00)
        else $error("self-test error did not set flag and count");

    AST_CHECK_CLEAR: assert property (
        check_clear && !check_event
        |=> state_q.check_count == 16'h0000 && !state_q.check_flag)
        else $error("checksum status not cleared by command");

    AST_PEAK_KEEPS: assert property (
        !(rd_fire && rd_idx == IDX_PIN0_VOLTAGE_EXTREMES)
        |=> state_q.pin0_peak_reading >= $past(state_q.pin0_peak_reading))
        else $error("pin0 peak reading dropped without a read");

    AST_TROUGH1_KEEPS: assert property (
        !(rd_fire && rd_idx == IDX_PIN1_VOLTAGE_EXTREMES)
        |=> state_q.pin1_trough_reading <= $past(state_q.pin1_trough_reading))
        else $error("pin1 trough reading rose without a read");

    AST_ALARM_STICKY: assert property (
        !(rd_fire && rd_idx == IDX_MONITOR_ALARM_FLAGS)
        |=> (state_q.alarms & $past(state_q.alarms)) == $past(state_q.alarms))
        else $error("alarm flag dropped without a read");

    AST_WRITE_ANSWER: assert property (
        wr_fire |=> bvalid && awready && wready)
        else $error("write answer missing after both halves held");

endmodule : lsd_regs

/* File: test/lsd_far_end.sv */
// Behavioural remote end that drives the back-link status inputs.
`timescale 1ns/10ps
module lsd_far_end
    import lsd_pkg::*;
(
    output lsd_link_s link_o,
    input wire logic aclk
);
    initial begin
        link_o = '0;
        link_o.backlink_valid = 1'b1;
        link_o.fwd_highspeed_pll_locked = 1'b1;
    end

    task automatic levels(input logic lk, input logic vl, input logic pl);
        @(posedge aclk);
        link_o.remote_lock <= lk;
        link_o.backlink_valid <= vl;
        link_o.fwd_highspeed_pll_locked <= pl;
        repeat (3) @(posedge aclk);
    endtask : levels

    // Errors arrive back to back, the densest spacing the link can give.
    task automatic errs(input int n, input logic bist);
        @(posedge aclk);
        link_o.selftest_mode <= bist;
        @(posedge aclk);
        link_o.backlink_err <= 1'b1;
        repeat (n) @(posedge aclk);
        link_o.backlink_err <= 1'b0;
        @(posedge aclk);
        link_o.selftest_mode <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : errs
endmodule : lsd_far_end

/* File: test/lsd_regs_tb.sv */
// Self-checking bench for the link status and diagnostic registers.
`timescale 1ns/10ps
module lsd_regs_tb;
    import lsd_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic [3:0] gpio = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    lsd_link_s link;
    lsd_sense_s sense = '0;
    int n_fail = 0;
    int n_compared = 0;
    int seed = 36991;
    int m_lk, m_lost, m_crc, m_bist, m_c16, m_c8, m_ctrl, m_alm, m_pin;
    int m_vl = 1;
    int m_pl = 1;
    int m_pk0, m_pk1;
    int m_tr0 = 7;
    int m_tr1 = 7;

    always #20 aclk = ~aclk;

    lsd_regs i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .gpio_pin(gpio), .link_i(link), .sense_i(sense));
    lsd_far_end i_far (.link_o(link), .aclk(aclk));

    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h not %h", $time, what,
                     got, exp);
        end
    endtask : chk

    // Address and data are offered together; each is dropped once taken.
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d,
                      input logic [1:0] er = RESP_OKAY,
                      input logic [3:0] s = 4'h1);
        logic a;
        logic w;
        a = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(a && w)) begin
            @(posedge aclk);
            if (!a && awready === 1'b1) begin
                a = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
        chk(bresp, er, "bresp");
    endtask : wr

    task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] ed,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, {24'h0, ed}, "rdata");
        chk(rresp, er, "rresp");
    endtask : rd

    function automatic logic [7:0] gen_exp();
        return 8'((m_lk << 6) | (m_lost << 4) | (m_bist << 3) |
                  (m_pl << 2) | (m_crc << 1) | m_vl);
    endfunction : gen_exp

    task automatic cnts();
        rd(IDX_LINK_GENERAL_FLAGS, gen_exp());
        rd(IDX_SELFTEST_FAIL_COUNT, 8'(m_c8));
        rd(IDX_CHECK_COUNT_LOW, 8'(m_c16));
        rd(IDX_CHECK_COUNT_HIGH, 8'(m_c16 >> 8));
    endtask : cnts

    task automatic lv(input int lk, input int vl, input int pl);
        // A link change in the same cycle as a lock loss still sets.
        if (m_pl == 1 && pl == 0) m_lost = 0;
        if (vl != m_vl) m_lost = 1;
        m_lk = lk;
        m_vl = vl;
        m_pl = pl;
        i_far.levels(1'(lk), 1'(vl), 1'(pl));
        rd(IDX_LINK_GENERAL_FLAGS, gen_exp());
    endtask : lv

    task automatic er(input int n, input int bist);
        i_far.errs(n, 1'(bist));
        if (bist == 1) begin
            m_bist = 1;
            m_c8 = (m_c8 + n > 255) ? 255 : m_c8 + n;
        end else if (m_vl == 1) begin
            m_crc = 1;
            m_c16 = (m_c16 + n > 65535) ? 65535 : m_c16 + n;
        end
        cnts();
    endtask : er

    task automatic clr();
        rd(IDX_BACKLINK_CTRL, 8'(m_ctrl));
        m_lost = 0;
        m_crc = 0;
        rd(IDX_LINK_GENERAL_FLAGS, gen_exp());
    endtask : clr

    task automatic wc(input logic [7:0] d);
        wr(IDX_BACKLINK_CTRL, d);
        m_ctrl = d & CTRL_KEEP_MASK;
        if (d[3]) begin
            m_crc = 0;
            m_c16 = 0;
        end
        if (d[5]) begin
            m_c8 = 0;
            m_bist = 0;
        end
        cnts();
    endtask : wc

    // Pins are asynchronous, so several edges pass before the read.
    task automatic pins(input int dir);
        logic [3:0] g;
        g = 4'($random(seed));
        @(posedge aclk);
        gpio <= g;
        repeat (5) @(posedge aclk);
        m_pin = (m_pin & ~dir) | (g & dir);
        rd(IDX_INPUT_PIN_LEVELS, 8'(m_pin));
    endtask : pins

    task automatic smp(input int n);
        logic [7:0] t;
        logic [2:0] a;
        logic [2:0] b;
        repeat (n) begin
            t = 8'($random(seed));
            a = 3'($random(seed));
            b = 3'($random(seed));
            @(posedge aclk);
            sense.sample_valid <= 1'b1;
            sense.temp_reading <= t;
            sense.pin0_reading <= a;
            sense.pin1_reading <= b;
            @(posedge aclk);
            sense.sample_valid <= 1'b0;
            if (t > 8'hc0) m_alm |= 32;
            if (t < 8'h40) m_alm |= 16;
            if (b > 3'h4) m_alm |= 8;
            if (b < 3'h1) m_alm |= 4;
            if (a > 3'h5) m_alm |= 2;
            if (a < 3'h2) m_alm |= 1;
            if (b > 3'h4 && b > m_pk1) m_pk1 = b;
            if (b < 3'h1 && b < m_tr1) m_tr1 = b;
            if (a > 3'h5 && a > m_pk0) m_pk0 = a;
            if (a < 3'h2 && a < m_tr0) m_tr0 = a;
        end
        repeat (2) @(posedge aclk);
    endtask : smp

    initial begin
        sense.temp_upper_limit = 8'hc0;
        sense.temp_lower_limit = 8'h40;
        sense.pin0_upper_limit = 3'h5;
        sense.pin0_lower_limit = 3'h2;
        sense.pin1_upper_limit = 3'h4;
        sense.pin1_lower_limit = 3'h1;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        cnts();
        rd(IDX_MONITOR_ALARM_FLAGS, 8'h00);
        rd(IDX_PIN0_VOLTAGE_EXTREMES, 8'h07);
        rd(IDX_PIN1_VOLTAGE_EXTREMES, 8'h07);
        rd(10'h060, 8'h00, RESP_SLVERR);
        wr(IDX_LINK_GENERAL_FLAGS, 8'hff);
        wr(10'h060, 8'hff, RESP_SLVERR);
        cnts();
        $display("reset and access test done");
        lv(1, 1, 1);
        lv(1, 0, 1);
        clr();
        lv(1, 1, 1);
        lv(1, 1, 0);
        lv(0, 1, 1);
        $display("link status test done");
        er(1 + ($random(seed) & 63), 0);
        er(3, 0);
        wc(8'h08);
        lv(0, 0, 1);
        er(5, 0);
        lv(0, 1, 1);
        clr();
        er(260, 1);
        wc(8'h20);
        er(7, 1);
        er(4, 0);
        clr();
        cnts();
        wc(8'h3f);
        clr();
        $display("error flag test done");
        pins(15);
        wr(IDX_PIN_DIRECTION, 8'h00, RESP_OKAY, 4'h0);
        pins(15);
        wr(IDX_PIN_DIRECTION, 8'h00);
        pins(0);
        wr(IDX_PIN_DIRECTION, 8'h05);
        pins(5);
        $display("pin level test done");
        repeat (3) begin
            smp(12);
            rd(IDX_MONITOR_ALARM_FLAGS, 8'(m_alm));
            m_alm = 0;
            rd(IDX_MONITOR_ALARM_FLAGS, 8'h00);
            rd(IDX_PIN0_VOLTAGE_EXTREMES, 8'(m_pk0*16+m_tr0));
            rd(IDX_PIN0_VOLTAGE_EXTREMES, 8'h07);
            rd(IDX_PIN1_VOLTAGE_EXTREMES, 8'(m_pk1*16+m_tr1));
            rd(IDX_PIN1_VOLTAGE_EXTREMES, 8'h07);
            m_pk0 = 0;
            m_pk1 = 0;
            m_tr0 = 7;
            m_tr1 = 7;
        end
        $display("sensor alarm test done");
        summarize();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        summarize();
    end
endmodule : lsd_regs_tb
